/* inc/ocp_amp_pkg.sv */
package ocp_amp_pkg;
    // Clock and time base
    localparam int CLK_MHZ = 250;
    localparam int TRIM_TIME_US = 50;
    localparam int TRIM_CYCLES = TRIM_TIME_US * CLK_MHZ;
    localparam int DEGLITCH_TIME_NS = 4000;
    localparam int DEGLITCH_CYCLES = (DEGLITCH_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int FILTER_TIME_NS = 16;
    localparam int FILTER_CYCLES = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int NUM_CH = 3;
    localparam int NUM_FET = 6;
    localparam int NUM_IN = 6;

    // Register map, word offsets as byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CAL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;

    // Control register fields
    localparam int CTRL_THR_LSB = 0;
    localparam int CTRL_GAIN_LSB = 4;
    localparam int CTRL_LSREF_BIT = 6;
    localparam int CTRL_FET_BIT = 7;
    localparam int CTRL_DIV_BIT = 8;
    localparam int CTRL_AUTOCAL_BIT = 9;
    localparam int CTRL_MODE_LSB = 10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

    // Status bits: six overcurrent flags, trim done
    localparam int STAT_TRIM_BIT = 6;
    localparam int STAT_W = 7;

    // Threshold codes: serial parts reach the top code, pin parts stop lower
    localparam logic [3:0] THR_MAX_SERIAL = 4'hF;
    localparam logic [3:0] THR_MAX_PIN = 4'hA;
    localparam logic [1:0] GAIN_MAX = 2'h3;

    typedef enum logic [1:0] {
        GAIN_5, GAIN_10, GAIN_20, GAIN_40
    } gain_t;

    typedef enum logic [1:0] {
        FM_LATCH, FM_RETRY, FM_REPORT, FM_IGNORE
    } fault_mode_t;

    // First member is the MSB, so the threshold lands on bits 3:0
    typedef struct packed {
        fault_mode_t fault_mode;
        logic auto_cal_enable;
        logic ref_divider_enable;
        logic fet_voltage_sense_mode;
        logic lowside_monitor_reference_select;
        gain_t amplifier_gain;
        logic [3:0] trip_threshold;
    } cfg_t;

    typedef struct packed {
        logic [1:0] gain_sel;
        logic inputs_shorted;
        logic load_disconnect;
        logic trim_run;
        logic ref_divider_on;
        logic lowside_monitor_reference_select_negative;
    } amp_ctrl_t;
endpackage

/* core/ocp_deglitch.sv */
module ocp_deglitch
    import ocp_amp_pkg::*;
#(
    parameter int COUNT = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic level_in,
    output logic detect
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    // Count while above threshold; any dip restarts the count
    assign nxt_cnt = !level_in ? '0 : (cnt_ff == LAST) ? cnt_ff :
                     cnt_ff + CW'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Fires only once the level outlasts the whole count
    assign detect = level_in && (cnt_ff == LAST);
endmodule

/* core/trim_sequencer.sv */
module trim_sequencer
    import ocp_amp_pkg::*;
#(
    parameter int TRIM_LEN = TRIM_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic running,
    output logic done
);
    localparam int CW = $clog2(TRIM_LEN + 1);
    localparam logic [CW-1:0] LAST = CW'(TRIM_LEN - 1);

    typedef enum logic {
        TS_IDLE, TS_RUN
    } trim_state_t;

    trim_state_t state_ff;
    trim_state_t nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic end_hit;

    assign end_hit = (state_ff == TS_RUN) && (cnt_ff == LAST);

    // A restart while running simply begins the count again
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            TS_IDLE: begin
                if (start) begin
                    nxt_state = TS_RUN;
                    nxt_cnt = '0;
                end
            end
            TS_RUN: begin
                if (start) begin
                    nxt_cnt = '0;
                end else if (end_hit) begin
                    nxt_state = TS_IDLE;
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
            default: begin
                nxt_state = TS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= TS_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign running = (state_ff == TS_RUN);
    assign done = end_hit && !start;
endmodule

/* core/ocp_amp_ctrl.sv */
// What this block does
// - An overcurrent is flagged only when a monitor stays above trip longer than the deglitch time, then the fault mode acts.
// - On serial parts a control bit picks shunt positive or negative as low-side monitor reference; high side always compares drain to switch node.
// - The trip threshold code spans 0.06 V to 2 V on serial parts and only up to 1 V on pin parts.
// - Amplifier gain is one of exactly four settings: 5, 10, 20 or 40 V/V.
// - Logic control inputs pass a short digital filter so that noise spikes do not change gate outputs.
// - On serial parts, clearing the divider bit removes the reference divider, making the amplifier unidirectional.
// - A per-channel calibration request shorts only that amplifier's inputs and disconnects its load.
// - Manual calibration exists only on serial parts; pin parts have no such control.
// - Calibration requests are taken at any moment, even while the bridges switch, never deferred.
// - Power-up auto trim starts as soon as the reference voltage first exceeds its minimum level.
// - With auto-cal enabled on serial parts, a channel calibration request reruns the auto trim instead.
// - While any auto trim runs, every amplifier is forced to maximum gain.
// - On serial parts, FET sense mode forces the low-side monitor reference to shunt negative, overriding the select bit.
//
// The address map and the plain strobed port were decided locally.
module ocp_amp_ctrl
    import ocp_amp_pkg::*;
#(
    parameter int TRIM_LEN = TRIM_CYCLES,
    parameter bit SERIAL_PART = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic vref_valid,
    input wire logic [NUM_FET-1:0] vds_above_trip,
    input wire logic [NUM_IN-1:0] gate_cmd_in,
    input wire logic [3:0] pin_threshold,
    input wire logic [1:0] pin_gain,
    output logic [NUM_IN-1:0] gate_cmd_filtered,
    output logic [3:0] overcurrent_trip_threshold,
    output logic [NUM_CH-1:0] lowside_monitor_reference_select_negative,
    output logic [NUM_CH*2-1:0] amp_gain_sel,
    output logic ref_divider_on,
    output logic [NUM_CH-1:0] amp_inputs_shorted,
    output logic [NUM_CH-1:0] amp_load_disconnect,
    output logic trim_active,
    output logic gate_shutdown,
    output logic fault_indicator_output_n,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // Register file
    cfg_t cfg_ff;
    logic [NUM_CH-1:0] cal_req_ff;
    logic [STAT_W-1:0] status_ff;
    logic [STAT_W-1:0] mask_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_ctrl;
    logic wr_cal;
    logic wr_status;
    logic wr_mask;
    logic [STAT_W-1:0] events;
    logic [STAT_W-1:0] nxt_status;
    // Status sources, declared early for the read mux
    logic trim_run;
    logic [NUM_FET-1:0] oc_level;

    // Write decode; unmapped addresses match nothing
    assign wr_ctrl = wr_en && (addr == ADDR_CTRL);
    assign wr_cal = wr_en && (addr == ADDR_CAL);
    assign wr_status = wr_en && (addr == ADDR_STATUS);
    assign wr_mask = wr_en && (addr == ADDR_MASK);

    // Read mux; unmapped addresses read as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (addr)
            ADDR_CTRL: nxt_rdata = 32'(cfg_ff);
            ADDR_CAL: nxt_rdata = 32'(cal_req_ff);
            ADDR_STATUS: nxt_rdata = 32'(status_ff);
            ADDR_MASK: nxt_rdata = 32'(mask_ff);
            ADDR_STATE: nxt_rdata = {25'h0, trim_run, oc_level};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Hardware set wins over a write-one clear in the same cycle
    assign nxt_status = (status_ff & ~(wr_status ? wdata[STAT_W-1:0] :
                        {STAT_W{1'b0}})) | events;

    // Pin parts take threshold and gain from strap pins, clamped
    logic [3:0] thr_req;
    logic [3:0] thr_lim;
    logic [3:0] thr_eff;
    assign thr_req = SERIAL_PART ? cfg_ff.trip_threshold : pin_threshold;
    assign thr_lim = SERIAL_PART ? THR_MAX_SERIAL : THR_MAX_PIN;
    assign thr_eff = (thr_req > thr_lim) ? thr_lim : thr_req;

    // Configuration and mask take plain writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_ff <= cfg_t'(CTRL_RESET[$bits(cfg_t)-1:0]);
            mask_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                cfg_ff <= cfg_t'(wdata[$bits(cfg_t)-1:0]);
            end
            if (wr_mask) begin
                mask_ff <= wdata[STAT_W-1:0];
            end
        end
    end

    // Sticky status flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Read data stands one cycle, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= rd_en ? nxt_rdata : 32'h0000_0000;
        end
    end

    assign rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Calibration requests: taken on any write, no gating by switching
    logic [NUM_CH-1:0] cal_set;
    logic auto_mode;
    logic rerun_trim;
    assign cal_set = (wr_cal && SERIAL_PART) ? wdata[NUM_CH-1:0] :
                     {NUM_CH{1'b0}};
    assign auto_mode = SERIAL_PART && cfg_ff.auto_cal_enable;
    // With auto-cal on, a request starts the trim routine instead
    assign rerun_trim = auto_mode && (|cal_set);

    // Manual requests hold until rewritten; auto mode keeps them clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_req_ff <= '0;
        end else if (wr_cal && SERIAL_PART && !auto_mode) begin
            cal_req_ff <= wdata[NUM_CH-1:0];
        end else if (auto_mode) begin
            cal_req_ff <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-up trim starts on the first rise of reference valid
    logic vref_seen_ff;
    logic trim_start;
    logic trim_done;
    assign trim_start = (vref_valid && !vref_seen_ff) || rerun_trim;

    // Sticky, so a later dip of the reference cannot trim again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vref_seen_ff <= 1'b0;
        end else if (vref_valid) begin
            vref_seen_ff <= 1'b1;
        end
    end

    // One sequencer serves power-up and run-time trims alike
    trim_sequencer #(
        .TRIM_LEN(TRIM_LEN)
    ) u_trim (
        .clk(clk),
        .rst(rst),
        .start(trim_start),
        .running(trim_run),
        .done(trim_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Overcurrent monitors, one deglitcher per MOSFET
    // A count per FET, so one noisy monitor cannot mask another
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FET; gi++) begin : g_mon
            ocp_deglitch #(
                .COUNT(DEGLITCH_CYCLES)
            ) u_deg (
                .clk(clk),
                .rst(rst),
                .level_in(vds_above_trip[gi]),
                .detect(oc_level[gi])
            );
        end
    endgenerate

    // Trim done sits above the six monitor flags
    assign events = {trim_done, oc_level};

    // Fault mode: latch and retry shut the gates, report only flags
    logic shut_req;
    logic report_req;
    assign shut_req = (|status_ff[NUM_FET-1:0]) &&
        ((cfg_ff.fault_mode == FM_LATCH) ||
         ((cfg_ff.fault_mode == FM_RETRY) && (|oc_level)));
    // Ignore mode still records the flag but keeps the pin quiet
    assign report_req = (|status_ff[NUM_FET-1:0]) &&
        (cfg_ff.fault_mode != FM_IGNORE);

    ////////////////////////////////////////////////////////////////////////
    // Input filter: a new input level must hold a few cycles
    localparam int FW = $clog2(FILTER_CYCLES + 1);
    localparam logic [FW-1:0] FLAST = FW'(FILTER_CYCLES);
    logic [NUM_IN-1:0] filt_ff;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
            logic [FW-1:0] fcnt_ff;
            // Count only while pin and output disagree
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    fcnt_ff <= '0;
                    filt_ff[gi] <= 1'b0;
                end else if (gate_cmd_in[gi] == filt_ff[gi]) begin
                    fcnt_ff <= '0;
                end else if (fcnt_ff == FLAST) begin
                    filt_ff[gi] <= gate_cmd_in[gi];
                    fcnt_ff <= '0;
                end else begin
                    fcnt_ff <= fcnt_ff + FW'(1);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Analog controls, all registered
    logic [1:0] gain_prog;
    logic [1:0] gain_eff;
    logic ls_neg;
    // Pin parts read gain from the strap, serial parts from the register
    assign gain_prog = SERIAL_PART ? cfg_ff.amplifier_gain : pin_gain;
    // Trim overrides gain only while it runs, so nothing is lost
    assign gain_eff = trim_run ? GAIN_MAX : gain_prog;
    // FET sense keeps the low-side monitor alive via shunt negative
    assign ls_neg = cfg_ff.fet_voltage_sense_mode ||
                    cfg_ff.lowside_monitor_reference_select;

    // Monitor threshold and reference routing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overcurrent_trip_threshold <= 4'h0;
            lowside_monitor_reference_select_negative <= '0;
            ref_divider_on <= 1'b1;
        end else begin
            overcurrent_trip_threshold <= thr_eff;
            lowside_monitor_reference_select_negative <= {NUM_CH{SERIAL_PART && ls_neg}};
            ref_divider_on <= !SERIAL_PART ||
                              cfg_ff.ref_divider_enable;
        end
    end

    // Gain and calibration switches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            amp_gain_sel <= '0;
            amp_inputs_shorted <= '0;
            amp_load_disconnect <= '0;
            trim_active <= 1'b0;
        end else begin
            amp_gain_sel <= {NUM_CH{gain_eff}};
            amp_inputs_shorted <= cal_req_ff |
                                  {NUM_CH{trim_run}};
            amp_load_disconnect <= cal_req_ff;
            trim_active <= trim_run;
        end
    end

    // Fault outputs; the mask gates irq only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_shutdown <= 1'b0;
            fault_indicator_output_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            gate_shutdown <= shut_req;
            fault_indicator_output_n <= !report_req;
            irq <= |(status_ff & mask_ff);
        end
    end

    // Gate commands held low during shutdown
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_cmd_filtered <= '0;
        end else begin
            gate_cmd_filtered <= filt_ff & {NUM_IN{!shut_req}};
        end
    end
endmodule

/* tb/bridge_sense_model.sv */
module bridge_sense_model
    import ocp_amp_pkg::*;
#(
    parameter int RAMP = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_on,
    input wire logic [NUM_FET-1:0] short_req,
    output logic vref_valid,
    output logic [NUM_FET-1:0] vds_above_trip
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ramp_ff;

    // Reference ramps up slowly, comparators lag the bridge by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ramp_ff <= 8'h00;
            vref_valid <= 1'b0;
            vds_above_trip <= '0;
        end else begin
            if (supply_on && ramp_ff != 8'(RAMP)) begin
                ramp_ff <= ramp_ff + 8'h01;
            end
            vref_valid <= (ramp_ff == 8'(RAMP));
            vds_above_trip <= short_req;
        end
    end
endmodule

/* tb/ocp_amp_ctrl_sva.sv */
module ocp_amp_ctrl_sva
    import ocp_amp_pkg::*;
#(
    parameter int TRIM_LEN = TRIM_CYCLES,
    parameter bit SERIAL_PART = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic vref_valid,
    input wire logic [NUM_FET-1:0] vds_above_trip,
    input wire logic [NUM_IN-1:0] gate_cmd_in,
    input wire logic [NUM_IN-1:0] gate_cmd_filtered,
    input wire logic [3:0] overcurrent_trip_threshold,
    input wire logic [NUM_CH-1:0] lowside_monitor_reference_select_negative,
    input wire logic [NUM_CH*2-1:0] amp_gain_sel,
    input wire logic ref_divider_on,
    input wire logic [NUM_CH-1:0] amp_inputs_shorted,
    input wire logic [NUM_CH-1:0] amp_load_disconnect,
    input wire logic trim_active,
    input wire logic gate_shutdown,
    input wire logic fault_indicator_output_n,
    input wire logic irq
);
    logic [31:0] ctrl_ff;
    logic [1:0] age_ff;
    logic hit_ff;
    logic seen_ff;
    logic [10:0] run_ff [NUM_FET];
    logic [NUM_FET-1:0] long_w;

    ////////////////////////////////////////////////////////////////////////
    // Shadow of the last control write; outputs are judged once settled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
            age_ff <= 2'h3;
        end else if (wr_en && addr == ADDR_CTRL) begin
            ctrl_ff <= wdata;
            age_ff <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end

    // Run length per monitor; saturates so long shorts do not wrap
    for (genvar i = 0; i < NUM_FET; i++) begin : g_run
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                run_ff[i] <= 11'h000;
            end else if (!vds_above_trip[i]) begin
                run_ff[i] <= 11'h000;
            end else if (run_ff[i] != 11'h7FF) begin
                run_ff[i] <= run_ff[i] + 11'h001;
            end
        end
        assign long_w[i] = run_ff[i] >= 11'h3E8;
    end

    // Sticky marks: a full deglitch run seen, reference rise seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            hit_ff <= hit_ff | (|long_w);
            seen_ff <= seen_ff | vref_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data not idle");
    cal_pair_a: assert property (amp_inputs_shorted ==
        (amp_load_disconnect | {3{trim_active}}))
        else $error("short and disconnect differ");
    lsref_sel_a: assert property (SERIAL_PART && age_ff == 2'h3
        |-> lowside_monitor_reference_select_negative == {3{ctrl_ff[7] | ctrl_ff[6]}})
        else $error("low-side reference wrong");
    div_ctrl_a: assert property (SERIAL_PART && age_ff == 2'h3
        |-> ref_divider_on == ctrl_ff[8])
        else $error("divider control wrong");
    thr_ctrl_a: assert property (SERIAL_PART && age_ff == 2'h3
        |-> overcurrent_trip_threshold == ctrl_ff[3:0])
        else $error("trip threshold wrong");
    gain_prog_a: assert property (SERIAL_PART && age_ff == 2'h3
        && !trim_active && !$past(trim_active) && !$past(trim_active, 2)
        |-> amp_gain_sel == {3{ctrl_ff[5:4]}})
        else $error("programmed gain wrong");
    gain_trim_a: assert property (trim_active && $past(trim_active)
        |-> amp_gain_sel == 6'h3F)
        else $error("gain not maximum in trim");
    shut_gate_a: assert property (gate_shutdown && $past(gate_shutdown)
        |-> gate_cmd_filtered == 6'h00)
        else $error("gates driven in shutdown");
    ocp_hit_a: assert property ($fell(fault_indicator_output_n) |-> hit_ff)
        else $error("fault without full deglitch run");
    filt_hold_a: assert property ($changed(gate_cmd_filtered[0])
        && !gate_shutdown && !$past(gate_shutdown) && !$past(gate_shutdown, 2)
        |-> $past(gate_cmd_in[0], 2) == gate_cmd_filtered[0]
        && $past(gate_cmd_in[0], 4) == gate_cmd_filtered[0])
        else $error("filter passed a short pulse");
    trim_start_a: assert property ($rose(vref_valid) && !seen_ff
        |-> ##[1:3] trim_active)
        else $error("power-up trim late");

    // Main scenarios reached
    trim_c: cover property ($rose(trim_active));
    fault_c: cover property ($fell(fault_indicator_output_n));
    irq_c: cover property ($rose(irq));
endmodule

/* tb/ocp_amp_ctrl_bench.sv */
module ocp_amp_ctrl_bench import ocp_amp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, supply_on = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [5:0] gate_cmd_in = 6'h00, short_req = 6'h00;
    logic [5:0] vds_above_trip, gate_cmd_filtered, amp_gain_sel;
    logic [3:0] overcurrent_trip_threshold;
    logic [2:0] lowside_monitor_reference_select_negative, amp_inputs_shorted, amp_load_disconnect;
    logic vref_valid, ref_divider_on, trim_active, gate_shutdown;
    logic fault_indicator_output_n, irq;
    int errors = 0, cmp_count = 0;

    always #2 clk = ~clk;

    ocp_amp_ctrl #(.TRIM_LEN(20), .SERIAL_PART(1'b1)) u_ocp_amp_ctrl (
        .clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .vref_valid,
        .vds_above_trip, .gate_cmd_in, .pin_threshold(4'h0), .pin_gain(2'h0),
        .gate_cmd_filtered, .overcurrent_trip_threshold, .lowside_monitor_reference_select_negative,
        .amp_gain_sel, .ref_divider_on, .amp_inputs_shorted,
        .amp_load_disconnect, .trim_active, .gate_shutdown,
        .fault_indicator_output_n, .irq);

    bridge_sense_model u_bridge_sense_model (.clk, .rst, .supply_on,
        .short_req, .vref_valid, .vds_above_trip);

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers; every bus task starts on a fresh edge
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait on the trim flag, so a stuck sequencer cannot hang us
    task automatic wait_on(input logic want);
        int k;
        k = 0;
        while (trim_active !== want && k < 200) begin
            cyc(1);
            k++;
        end
        chk(k < 200, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(ADDR_CTRL, CTRL_RESET);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0);
        rd(ADDR_STATE, 32'h0);
        chk(ref_divider_on, 1'b1);
    endtask

    task automatic t_power;
        @(posedge clk) supply_on <= 1'b1;
        wait_on(1'b1);
        cyc(2);
        chk(amp_gain_sel, 6'h3F);
        wait_on(1'b0);
        cyc(3);
        chk(amp_gain_sel, 6'h00);
        rd(ADDR_STATUS, 32'h40);
        wr(ADDR_STATUS, 32'h40);
        rd(ADDR_STATUS, 32'h0);
    endtask

    task automatic t_cfg;
        for (int g = 0; g < 4; g++) begin
            wr(ADDR_CTRL, 32'h10F | (g << 4));
            cyc(3);
            chk(amp_gain_sel, {3{g[1:0]}});
        end
        wr(ADDR_CTRL, 32'h04F);
        cyc(3);
        chk({lowside_monitor_reference_select_negative, ref_divider_on, overcurrent_trip_threshold}, 8'hEF);
        wr(ADDR_CTRL, 32'h180);
        cyc(3);
        chk(lowside_monitor_reference_select_negative, 3'h7);
        wr(ADDR_CTRL, 32'h100);
        cyc(3);
        chk(lowside_monitor_reference_select_negative, 3'h0);
    endtask

    // Calibration while the bridge inputs are active, then auto mode
    task automatic t_cal;
        @(posedge clk) gate_cmd_in <= 6'h15;
        wr(ADDR_CAL, 32'h2);
        cyc(3);
        chk({amp_inputs_shorted, amp_load_disconnect}, 6'h12);
        rd(ADDR_CAL, 32'h2);
        @(posedge clk) gate_cmd_in <= 6'h00;
        wr(ADDR_CAL, 32'h4);
        cyc(3);
        chk({amp_inputs_shorted, amp_load_disconnect}, 6'h24);
        wr(ADDR_CAL, 32'h0);
        cyc(3);
        chk(amp_inputs_shorted, 3'h0);
        wr(ADDR_CTRL, 32'h300);
        wr(ADDR_CAL, 32'h1);
        wait_on(1'b1);
        cyc(2);
        chk(amp_gain_sel, 6'h3F);
        wait_on(1'b0);
        wr(ADDR_CTRL, 32'h100);
        cyc(3);
        chk(amp_gain_sel, 6'h00);
    endtask

    task automatic t_filter;
        @(posedge clk) gate_cmd_in <= 6'h00;
        repeat (10) @(posedge clk);
        gate_cmd_in <= 6'h01;
        repeat (3) @(posedge clk);
        gate_cmd_in <= 6'h00;
        cyc(8);
        chk(gate_cmd_filtered, 6'h00);
        @(posedge clk) gate_cmd_in <= 6'h01;
        cyc(10);
        chk(gate_cmd_filtered, 6'h01);
    endtask

    // A dip restarts the deglitch; the full run trips, mask, then clear
    task automatic overcurrent_deglitch_time;
        wr(ADDR_STATUS, 32'h7F);
        wr(ADDR_MASK, 32'h00);
        @(posedge clk) short_req <= 6'h01;
        repeat (900) @(posedge clk);
        short_req <= 6'h00;
        repeat (5) @(posedge clk);
        short_req <= 6'h01;
        cyc(990);
        chk(fault_indicator_output_n, 1'b1);
        cyc(20);
        chk({gate_shutdown, fault_indicator_output_n, gate_cmd_filtered}, 8'h80);
        rd(ADDR_STATE, 32'h1);
        rd(ADDR_STATUS, 32'h1);
        @(posedge clk) short_req <= 6'h00;
        wr(ADDR_MASK, 32'h7F);
        cyc(3);
        chk(irq, 1'b1);
        wr(ADDR_MASK, 32'h00);
        cyc(3);
        chk(irq, 1'b0);
        wr(ADDR_STATUS, 32'h7F);
        cyc(4);
        chk({irq, gate_shutdown, fault_indicator_output_n}, 3'h1);
        rd(ADDR_STATUS, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_power();
        t_cfg();
        t_cal();
        t_filter();
        overcurrent_deglitch_time();
        tally_and_finish();
    end

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule

bind ocp_amp_ctrl ocp_amp_ctrl_sva #(.TRIM_LEN(TRIM_LEN),
    .SERIAL_PART(SERIAL_PART)) u_ocp_amp_ctrl_sva (.clk, .rst, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .vref_valid, .vds_above_trip, .gate_cmd_in,
    .gate_cmd_filtered, .overcurrent_trip_threshold, .lowside_monitor_reference_select_negative,
    .amp_gain_sel, .ref_divider_on, .amp_inputs_shorted,
    .amp_load_disconnect, .trim_active, .gate_shutdown,
    .fault_indicator_output_n, .irq);
